// ---- design/cpu_regs_cfg.svh ----
// Purpose: constants of the CPU register and flag unit
// Assumes: included by both design modules and the bench; the package does not include it
// Notes: definitions only
`ifndef CPU_REGS_CFG_SVH
`define CPU_REGS_CFG_SVH

// ************************************************************
// Flag bit positions
// ************************************************************
`define FLAG_I 7
`define FLAG_U1 6
`define FLAG_H 5
`define FLAG_U0 4
`define FLAG_N 3
`define FLAG_Z 2
`define FLAG_V 1
`define FLAG_C 0

// ************************************************************
// Flag update masks
// ************************************************************
`define MASK_ARITH 8'h2F
`define MASK_NZV 8'h0E
`define MASK_NZVC 8'h0F
`define MASK_NZC 8'h0D
`define MASK_NZ 8'h0C
`define MASK_C 8'h01
`define MASK_USER 8'h50
`define MASK_I 8'h80

// ************************************************************
// Reset values and steps
// ************************************************************
`define FLAGS_RST_VAL 8'h80
`define PROG_RST_VAL 16'h0000
`define VEC_ADDR 16'h0000
`define PROG_STEP 16'h0002
`define STACK_STEP 16'h0002
`define EVEN_MASK 16'hFFFE
`define STACK_WORD 3'h7

`endif

// ---- design/cpu_regs_pkg.sv ----
// Purpose: types of the CPU register and flag unit
// Assumes: nothing
// Notes: operation and flag-register command encodings
package cpu_regs_pkg;

  // ************************************************************
  // Execution operations
  // ************************************************************
  typedef enum logic [4:0] {
    OP_MOV, OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW, OP_CMP,
    OP_NEGATE, OP_AND, OP_OR, OP_XOR, OP_SHL, OP_SHR, OP_ROTC,
    OP_DEC_ADD, OP_DEC_SUB, OP_ADDR_ADD, OP_ADDR_SUB, OP_MUL,
    OP_DIV, OP_BSET, OP_BCLR, OP_BSTORE, OP_BLOAD, OP_BAND, OP_BOR
  } alu_op_t;

  // ************************************************************
  // Direct flag-register commands
  // ************************************************************
  typedef enum logic [2:0] {
    FL_NONE, FL_LOAD, FL_AND, FL_OR, FL_XOR, FL_RESTORE
  } flags_op_t;

endpackage : cpu_regs_pkg

// ---- design/alu_flag_calc.sv ----
// Purpose: result and flag computation for one operation
// Assumes: byte operands arrive zero-extended to 16 bits
// Notes: purely combinational
`timescale 1ns/100ps
`include "cpu_regs_cfg.svh"

module alu_flag_calc (
  input cpu_regs_pkg::alu_op_t op, // Operation
  input logic word, // Word-size operation
  input logic [15:0] a, // Destination operand
  input logic [15:0] b, // Source operand
  input logic [2:0] bit_idx, // Bit number in a byte
  input logic [7:0] flags_in, // Current flags
  output logic [15:0] res, // Result
  output logic [7:0] flags, // New flag values
  output logic [7:0] mask, // Flags updated by this op
  output logic writes // Result is written back
);
  import cpu_regs_pkg::*;

  // ************************************************************
  // Adder and subtractor
  // ************************************************************
  wire logic cin = flags_in[`FLAG_C]; // Carry in
  wire logic is_sub = op == OP_SUB || op == OP_SUB_BORROW ||
                      op == OP_CMP || op == OP_NEGATE;
  wire logic use_c = op == OP_ADD_CARRY || op == OP_SUB_BORROW;
  wire logic ci = use_c & cin; // Carry or borrow into bit 0
  wire logic [15:0] x = (op == OP_NEGATE) ? 16'h0000 : a;
  wire logic [15:0] y = (op == OP_NEGATE) ? a : b;
  wire logic [16:0] sum = is_sub ?
    {1'b0, x} - {1'b0, y} - {16'h0000, ci} :
    {1'b0, x} + {1'b0, y} + {16'h0000, ci};
  wire logic [12:0] s12 = is_sub ?
    {1'b0, x[11:0]} - {1'b0, y[11:0]} - {12'h000, ci} :
    {1'b0, x[11:0]} + {1'b0, y[11:0]} + {12'h000, ci};
  wire logic [4:0] s4 = is_sub ?
    {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci} :
    {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
  wire logic carry = word ? sum[16] : sum[8];
  wire logic half = word ? s12[12] : s4[4];
  wire logic xm = word ? x[15] : x[7]; // Operand signs
  wire logic ym = word ? y[15] : y[7];
  wire logic rm = word ? sum[15] : sum[7];
  wire logic ovf = is_sub ? (xm != ym) && (rm != xm) :
                            (xm == ym) && (rm != xm);

  // ************************************************************
  // Bit, decimal, multiply and divide helpers
  // ************************************************************
  wire logic [7:0] bm = 8'h01 << bit_idx;
  wire logic bsel = a[bit_idx];
  wire logic lo_fix = flags_in[`FLAG_H] | (a[3:0] > 4'h9);
  wire logic hi_fix = cin | (a[7:0] > 8'h99);
  wire logic [7:0] daa_val = a[7:0] + (lo_fix ? 8'h06 : 8'h00) +
                             (hi_fix ? 8'h60 : 8'h00);
  wire logic [7:0] das_val = a[7:0] -
    (flags_in[`FLAG_H] ? 8'h06 : 8'h00) - (cin ? 8'h60 : 8'h00);
  wire logic [15:0] prod = {8'h00, a[7:0]} * {8'h00, b[7:0]};
  wire logic div_zero = b[7:0] == 8'h00; // Quotient undefined
  wire logic [15:0] quo = div_zero ? a : a / {8'h00, b[7:0]};
  wire logic [15:0] rmd = div_zero ? a : a % {8'h00, b[7:0]};

  // Result and flag selection
  logic c_v; // New carry
  logic v_v; // New overflow
  logic n_v; // New negative
  logic z_v; // New zero
  always_comb begin
    res = sum[15:0];
    c_v = carry;
    v_v = 1'b0;
    mask = 8'h00;
    writes = 1'b1;
    unique case (op)
      OP_MOV: begin res = b; mask = `MASK_NZV; end
      OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW, OP_NEGATE: begin
        v_v = ovf;
        mask = `MASK_ARITH;
      end
      OP_CMP: begin v_v = ovf; mask = `MASK_ARITH; writes = 1'b0; end
      OP_AND: begin res = a & b; mask = `MASK_NZV; end
      OP_OR: begin res = a | b; mask = `MASK_NZV; end
      OP_XOR: begin res = a ^ b; mask = `MASK_NZV; end
      OP_SHL: begin
        res = {8'h00, a[6:0], 1'b0};
        c_v = a[7];
        mask = `MASK_NZVC;
      end
      OP_SHR: begin
        res = {9'h000, a[7:1]};
        c_v = a[0];
        mask = `MASK_NZVC;
      end
      OP_ROTC: begin
        res = {8'h00, a[6:0], cin};
        c_v = a[7];
        mask = `MASK_NZVC;
      end
      OP_DEC_ADD: begin
        res = {8'h00, daa_val};
        c_v = hi_fix;
        mask = `MASK_NZC;
      end
      OP_DEC_SUB: begin
        res = {8'h00, das_val};
        c_v = cin;
        mask = `MASK_NZC;
      end
      OP_ADDR_ADD: res = a + b;
      OP_ADDR_SUB: res = a - b;
      OP_MUL: res = prod;
      OP_DIV: begin res = {rmd[7:0], quo[7:0]}; mask = `MASK_NZ; end
      OP_BSET: res = {8'h00, a[7:0] | bm};
      OP_BCLR: res = {8'h00, a[7:0] & ~bm};
      OP_BSTORE: res = {8'h00, cin ? a[7:0] | bm : a[7:0] & ~bm};
      OP_BLOAD: begin c_v = bsel; mask = `MASK_C; writes = 1'b0; end
      OP_BAND: begin c_v = cin & bsel; mask = `MASK_C; writes = 1'b0; end
      OP_BOR: begin c_v = cin | bsel; mask = `MASK_C; writes = 1'b0; end
    endcase
    n_v = word ? res[15] : res[7];
    z_v = word ? (res == 16'h0000) : (res[7:0] == 8'h00);
    if (op == OP_DIV) begin
      n_v = b[7];
      z_v = div_zero;
    end
    if (use_c) begin
      z_v = z_v & flags_in[`FLAG_Z]; // Zero only sticks across chains
    end
    flags = {flags_in[7:6], half, flags_in[4], n_v, z_v, v_v, c_v};
  end

endmodule : alu_flag_calc

// ---- design/cpu_register_and_flag_unit.sv ----
// Purpose: programmer-visible state of an 8-bit CPU core
// Assumes: sequencer outside issues at most one operation a cycle
// Notes: general registers, flags, program counter, branch test
`timescale 1ns/100ps
`include "cpu_regs_cfg.svh"

module cpu_register_and_flag_unit (
  input logic ref_clk, // System clock
  input logic rst_b, // Asynchronous reset, active low
  input logic ex_valid, // Execute one operation
  input cpu_regs_pkg::alu_op_t ex_op, // Operation
  input logic ex_word, // Word size, else byte
  input logic [3:0] ex_dst, // Destination register index
  input logic [3:0] ex_src, // Source register index
  input logic ex_use_imm, // Source is ex_imm
  input logic [15:0] ex_imm, // Immediate or memory operand
  input logic [2:0] ex_bit, // Bit number
  input cpu_regs_pkg::flags_op_t flags_op, // Direct flag command
  input logic [15:0] flags_src, // Flag command operand
  input logic exc_start, // Exception handling begins
  input logic stack_push, // Stack pointer down one word
  input logic stack_pop, // Stack pointer up one word
  input logic [3:0] rd_idx, // Read port register index
  input logic rd_word, // Read port word size
  input logic [2:0] ptr_idx, // Pointer register index
  input logic ptr_word, // Pointer used for a word access
  input logic prog_advance, // Step to next instruction word
  input logic prog_load, // Jump
  input logic [15:0] prog_target, // Jump address
  input logic vec_valid, // Reset vector word is present
  input logic [15:0] vec_data, // Reset vector word
  input logic [3:0] br_cond, // Branch condition code
  output logic [15:0] rd_data, // Read port data
  output logic [15:0] ptr_addr, // Memory address from pointer
  output logic [15:0] stack_pointer, // Current stack top
  output logic [15:0] program_counter, // Next instruction address
  output logic [15:0] vec_addr, // Where the reset vector sits
  output logic vec_req, // Reset vector fetch pending
  output logic [7:0] condition_code_register, // Flags
  output logic [15:0] flags_stack_word, // Flags as stacked
  output logic br_taken // Branch condition result
);
  import cpu_regs_pkg::*;

  // ************************************************************
  // General register storage
  // ************************************************************
  logic [7:0] general_high_bytes [8]; // Upper halves
  logic [7:0] general_low_bytes [8]; // Lower halves

  // Word view of a register pair
  function automatic logic [15:0] word_of(input logic [2:0] n);
    word_of = {general_high_bytes[n], general_low_bytes[n]};
  endfunction : word_of

  // Byte view: index 0-7 upper halves, 8-15 lower halves
  function automatic logic [7:0] byte_of(input logic [3:0] n);
    byte_of = n[3] ? general_low_bytes[n[2:0]] :
                     general_high_bytes[n[2:0]];
  endfunction : byte_of

  // ************************************************************
  // Operand selection
  // ************************************************************
  wire logic mul_div = ex_op == OP_MUL || ex_op == OP_DIV;
  wire logic addr_op = ex_op == OP_ADDR_ADD || ex_op == OP_ADDR_SUB;
  wire logic a_word = ex_word | mul_div | addr_op;
  wire logic b_word = (ex_word | addr_op) & ~mul_div;
  wire logic [15:0] src_val = ex_use_imm ? ex_imm :
    (b_word ? word_of(ex_src[2:0]) : {8'h00, byte_of(ex_src)});
  wire logic [15:0] b_val = b_word ? src_val : {8'h00, src_val[7:0]};
  wire logic [15:0] a_val = a_word ? word_of(ex_dst[2:0]) :
                            {8'h00, byte_of(ex_dst)};
  wire logic [15:0] alu_res; // Operation result
  wire logic [7:0] alu_flags; // Operation flag values
  wire logic [7:0] alu_mask; // Affected flags
  wire logic alu_writes; // Result goes to destination
  logic [7:0] flags_reg; // Flag register

  // Result and flag computation
  alu_flag_calc u_alu (
    .op(ex_op),
    .word(a_word),
    .a(a_val),
    .b(b_val),
    .bit_idx(ex_bit),
    .flags_in(flags_reg),
    .res(alu_res),
    .flags(alu_flags),
    .mask(alu_mask),
    .writes(alu_writes)
  );

  // ************************************************************
  // Register write-back and stack pointer
  // ************************************************************
  wire logic wr_en = ex_valid & alu_writes; // Single-cycle write
  wire logic stack_adj = stack_push ^ stack_pop; // Both at once cancel
  wire logic [15:0] top_word = word_of(`STACK_WORD);
  wire logic [15:0] stack_next = stack_push ?
    top_word - `STACK_STEP : top_word + `STACK_STEP;

  // No reset: contents stay unknown until software loads them
  always_ff @(posedge ref_clk) begin
    if (wr_en && a_word) begin
      general_high_bytes[ex_dst[2:0]] <= alu_res[15:8];
      general_low_bytes[ex_dst[2:0]] <= alu_res[7:0];
    end else if (wr_en && ex_dst[3]) begin
      general_low_bytes[ex_dst[2:0]] <= alu_res[7:0];
    end else if (wr_en) begin
      general_high_bytes[ex_dst[2:0]] <= alu_res[7:0];
    end
    if (stack_adj) begin // Stack adjust wins over a same-cycle write
      general_high_bytes[`STACK_WORD] <= stack_next[15:8];
      general_low_bytes[`STACK_WORD] <= stack_next[7:0];
    end
  end

  // ************************************************************
  // Read, pointer and stack ports
  // ************************************************************
  wire logic [15:0] ptr_src = word_of(ptr_idx);
  wire logic [15:0] rd_next = rd_word ? word_of(rd_idx[2:0]) :
                              {8'h00, byte_of(rd_idx)};
  wire logic [15:0] ptr_next = ptr_word ? ptr_src & `EVEN_MASK :
                               ptr_src;

  // Registered read-out of register views
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 16'h0000;
      ptr_addr <= 16'h0000;
      stack_pointer <= 16'h0000;
    end else begin
      rd_data <= rd_next;
      ptr_addr <= ptr_next;
      stack_pointer <= top_word;
    end
  end

  // ************************************************************
  // Program counter and reset vector
  // ************************************************************
  logic [15:0] prog_reg; // Program counter
  logic vec_req_reg; // Vector fetch pending
  wire logic [15:0] prog_next = vec_req_reg ?
    (vec_valid ? vec_data & `EVEN_MASK : prog_reg) :
    prog_load ? prog_target & `EVEN_MASK :
    prog_advance ? prog_reg + `PROG_STEP : prog_reg;

  // Vector load after reset, then jumps and steps
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prog_reg <= `PROG_RST_VAL;
      vec_req_reg <= 1'b1;
      vec_addr <= `VEC_ADDR;
    end else begin
      prog_reg <= prog_next;
      vec_req_reg <= vec_req_reg & ~vec_valid;
      vec_addr <= `VEC_ADDR;
    end
  end
  assign program_counter = prog_reg;
  assign vec_req = vec_req_reg;

  // ************************************************************
  // Flag register
  // ************************************************************
  wire logic [7:0] src_lo = flags_src[7:0]; // Command operand
  wire logic [7:0] src_hi = flags_src[15:8]; // Stacked upper byte
  wire logic [7:0] alu_merge = (flags_reg & ~alu_mask) |
                               (alu_flags & alu_mask);
  wire logic [7:0] flags_sel =
    (flags_op == FL_LOAD) ? src_lo :
    (flags_op == FL_AND) ? flags_reg & src_lo :
    (flags_op == FL_OR) ? flags_reg | src_lo :
    (flags_op == FL_XOR) ? flags_reg ^ src_lo :
    (flags_op == FL_RESTORE) ? src_hi :
    ex_valid ? alu_merge : flags_reg;
  wire logic [7:0] flags_next = flags_sel |
                                (exc_start ? `MASK_I : 8'h00);

  // Flag update; exception mask set wins over any clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_reg <= `FLAGS_RST_VAL;
      flags_stack_word <= {`FLAGS_RST_VAL, `FLAGS_RST_VAL};
    end else begin
      flags_reg <= flags_next;
      flags_stack_word <= {flags_next, flags_next};
    end
  end
  assign condition_code_register = flags_reg;

  // ************************************************************
  // Branch condition
  // ************************************************************
  wire logic n_flag = flags_reg[`FLAG_N];
  wire logic z_flag = flags_reg[`FLAG_Z];
  wire logic v_flag = flags_reg[`FLAG_V];
  wire logic c_flag = flags_reg[`FLAG_C];
  wire logic nv = n_flag ^ v_flag; // Signed less-than
  wire logic [7:0] br_false = {z_flag | nv, nv, n_flag, v_flag,
                               z_flag, c_flag, c_flag | z_flag, 1'b0};
  wire logic br_next = ~br_false[br_cond[3:1]] ^ br_cond[0];

  // Registered branch decision
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      br_taken <= 1'b0;
    end else begin
      br_taken <= br_next;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_prog_even;
    program_counter[0] == 1'b0;
  endproperty
  a_prog_even: assert property (p_prog_even)
    else $error("program counter is odd");

  property p_vec_load;
    vec_req && vec_valid |=>
      !vec_req && program_counter == ($past(vec_data) & 16'hFFFE);
  endproperty
  a_vec_load: assert property (p_vec_load)
    else $error("reset vector not loaded");

  property p_exc_mask;
    exc_start |=> condition_code_register[7];
  endproperty
  a_exc_mask: assert property (p_exc_mask)
    else $error("interrupt mask not set on exception");

  property p_load_flags;
    flags_op == FL_LOAD && !exc_start |=>
      condition_code_register == $past(src_lo);
  endproperty
  a_load_flags: assert property (p_load_flags)
    else $error("flag load lost");

  property p_stack_word;
    flags_stack_word[15:8] == flags_stack_word[7:0] &&
    flags_stack_word[7:0] == condition_code_register;
  endproperty
  a_stack_word: assert property (p_stack_word)
    else $error("stacked flag word halves differ");

  property p_restore;
    flags_op == FL_RESTORE && !exc_start |=>
      condition_code_register == $past(src_hi);
  endproperty
  a_restore: assert property (p_restore)
    else $error("flag restore not from upper byte");

  property p_user_bits;
    flags_op == FL_NONE |=> (condition_code_register & 8'h50) ==
      ($past(condition_code_register) & 8'h50);
  endproperty
  a_user_bits: assert property (p_user_bits)
    else $error("user bit changed by hardware");

  property p_addr_keep;
    ex_valid && addr_op && flags_op == FL_NONE && !exc_start |=>
      $stable(condition_code_register);
  endproperty
  a_addr_keep: assert property (p_addr_keep)
    else $error("address add changed flags");

  property p_stack_push;
    stack_push && !stack_pop |=> top_word == $past(top_word) - 16'h0002;
  endproperty
  a_stack_push: assert property (p_stack_push)
    else $error("stack push did not step down one word");

  property p_ptr_even;
    ptr_word |=> ptr_addr == ($past(ptr_src) & 16'hFFFE);
  endproperty
  a_ptr_even: assert property (p_ptr_even)
    else $error("word pointer not forced even");

  property p_br_eq;
    br_cond == 4'h7 |=> br_taken == $past(z_flag);
  endproperty
  a_br_eq: assert property (p_br_eq)
    else $error("equal branch does not follow zero flag");

endmodule : cpu_register_and_flag_unit

// ---- tb/cpu_register_and_flag_unit_tb.sv ----
// Purpose: self-checking bench of the register and flag unit
// Assumes: one clock; operands mostly come from the immediate
// Notes: expected values come from an integer model in the bench
`timescale 1ns/100ps
`include "cpu_regs_cfg.svh"

module cpu_register_and_flag_unit_tb;
  import cpu_regs_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0, ex_valid = 1'b0, ex_word = 1'b0;
  alu_op_t ex_op = OP_MOV;
  flags_op_t flags_op = FL_NONE;
  logic [3:0] ex_dst = 4'h0, ex_src = 4'h0, rd_idx = 4'h0, br_cond = 4'h0;
  logic [15:0] ex_imm = 16'h0000, flags_src = 16'h0000;
  logic [15:0] prog_target = 16'h0000, vec_data = 16'h0000;
  logic exc_start = 1'b0, stack_push = 1'b0, stack_pop = 1'b0;
  logic rd_word = 1'b0, ex_use_imm = 1'b1;
  logic ptr_word = 1'b0, prog_advance = 1'b0, prog_load = 1'b0;
  logic vec_valid = 1'b0;
  logic [2:0] ptr_idx = 3'h0, ex_bit = 3'h0;
  logic [15:0] rd_data, ptr_addr, stack_pointer, program_counter;
  logic [15:0] vec_addr, flags_stack_word;
  logic [7:0] flg; // Flags as the unit shows them
  logic vec_req, br_taken;
  int miscompares = 0, tests_run = 0, cycles = 0;

  cpu_register_and_flag_unit u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .ex_valid(ex_valid), .ex_op(ex_op),
    .ex_word(ex_word), .ex_dst(ex_dst), .ex_src(ex_src),
    .ex_use_imm(ex_use_imm), .ex_imm(ex_imm), .ex_bit(ex_bit),
    .flags_op(flags_op), .flags_src(flags_src), .exc_start(exc_start),
    .stack_push(stack_push), .stack_pop(stack_pop), .rd_idx(rd_idx),
    .rd_word(rd_word), .ptr_idx(ptr_idx), .ptr_word(ptr_word),
    .prog_advance(prog_advance), .prog_load(prog_load),
    .prog_target(prog_target), .vec_valid(vec_valid),
    .vec_data(vec_data), .br_cond(br_cond), .rd_data(rd_data),
    .ptr_addr(ptr_addr), .stack_pointer(stack_pointer),
    .program_counter(program_counter), .vec_addr(vec_addr),
    .vec_req(vec_req), .condition_code_register(flg),
    .flags_stack_word(flags_stack_word), .br_taken(br_taken));

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // Wait for edges, then step just past the last one
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One operation; its source is ex_imm while ex_use_imm is set
  task automatic exe(input alu_op_t op, input int w, d, v);
    ex_valid = 1'b1;
    ex_op = op;
    ex_word = w[0];
    ex_dst = d[3:0];
    ex_imm = v[15:0];
    cyc();
    ex_valid = 1'b0;
    cyc();
  endtask : exe

  // Direct flag command, then an idle edge
  task automatic fl(input flags_op_t op, input int v);
    flags_op = op;
    flags_src = v[15:0];
    cyc();
    flags_op = FL_NONE;
    cyc();
  endtask : fl

  task automatic rd(input int i, w, exp);
    rd_idx = i[3:0];
    rd_word = w[0];
    cyc();
    chk("rd_data", rd_data, exp[15:0]);
  endtask : rd

  // Add with random preset flags; user and mask bits must survive
  task automatic arith(input int w, a, b);
    int m, sb, r, h, f0, ex, d;
    m = w ? 16'hFFFF : 16'h00FF;
    sb = w ? 15 : 7;
    d = w ? 1 : 9;
    a = a & m;
    b = b & m;
    r = (a + b) & m;
    h = w ? ((a & 16'h0FFF) + (b & 16'h0FFF)) >> 12
          : ((a & 16'h000F) + (b & 16'h000F)) >> 4;
    f0 = $urandom & 8'hFF;
    ex = (f0 & 8'hD0) | (h << 5) | ((r >> sb) << 3) | ((r == 0) << 2)
       | (((((a ^ r) & (b ^ r)) >> sb) & 1) << 1) | ((a + b) >> (sb + 1));
    exe(OP_MOV, w, d, a);
    fl(FL_LOAD, f0);
    exe(OP_ADD, w, d, b);
    chk("flags", flg, ex);
    rd(d, w, r);
  endtask : arith

  // Expected branch outcome from N Z V C
  function automatic logic bexp(input int c, f);
    logic n, z, v, k;
    logic [15:0] t;
    {n, z, v, k} = f[3:0];
    t = {z | (n ^ v), ~(z | (n ^ v)), n ^ v, ~(n ^ v), n, ~n, v, ~v,
         z, ~z, k, ~k, k | z, ~(k | z), 1'b0, 1'b1};
    return t[c];
  endfunction : bexp

  initial begin
    int v, f;
    v = $urandom(32'hDD65AF36);
    cyc(4);
    chk("flags", flg, 16'h0080);
    chk("stack word", flags_stack_word, 16'h8080);
    chk("counter", program_counter, 16'h0000);
    chk("vec_addr", vec_addr, 16'h0000);
    chk("vec_req", vec_req, 16'h0001);
    rst_b = 1'b1;
    prog_advance = 1'b1;
    prog_load = 1'b1;
    prog_target = 16'h2222;
    cyc();
    chk("counter", program_counter, 16'h0000);
    v = $urandom | 1;
    vec_valid = 1'b1;
    vec_data = v[15:0];
    prog_load = 1'b0;
    cyc();
    vec_valid = 1'b0;
    chk("counter", program_counter, v[15:0] & 16'hFFFE);
    chk("vec_req", vec_req, 16'h0000);
    cyc();
    prog_advance = 1'b0;
    prog_load = 1'b1;
    prog_target = 16'hABCD;
    chk("counter", program_counter, (v[15:0] & 16'hFFFE) + 16'h0002);
    cyc();
    prog_load = 1'b0;
    chk("counter", program_counter, 16'hABCC);
    $display("test program counter done");
    for (int i = 0; i < 4; i++) begin
      v = $urandom & 8'hFF;
      fl(flags_op_t'(i + 1), v);
      f = i == 0 ? v : i == 1 ? f & v : i == 2 ? f | v : f ^ v;
      chk("flags", flg, f[7:0]);
      chk("stack word", flags_stack_word, {f[7:0], f[7:0]});
    end
    v = $urandom & 16'hFFFF;
    fl(FL_RESTORE, v);
    chk("flags", flg, v[15:8]);
    fl(FL_LOAD, 0);
    exc_start = 1'b1;
    cyc();
    exc_start = 1'b0;
    chk("flags", flg, 16'h0080);
    $display("test flags done");
    arith(0, 8'h7F, 8'h01);
    arith(1, 16'hFFFF, 16'h0001);
    for (int i = 0; i < 12; i++) arith(i & 1, $urandom, $urandom);
    exe(OP_MOV, 0, 9, 8'h3C);
    exe(OP_MOV, 0, 1, 8'hA5);
    rd(1, 1, 16'hA53C);
    rd(9, 0, 16'h003C);
    $display("test arithmetic done");
    exe(OP_MOV, 1, 2, 16'h1235);
    ptr_idx = 3'h2;
    ptr_word = 1'b1;
    cyc();
    chk("ptr_addr", ptr_addr, 16'h1234);
    ptr_word = 1'b0;
    cyc();
    chk("ptr_addr", ptr_addr, 16'h1235);
    exe(OP_MOV, 1, 7, 16'h4000);
    stack_push = 1'b1;
    cyc();
    stack_push = 1'b0;
    cyc(2);
    chk("stack_pointer", stack_pointer, 16'h3FFE);
    stack_pop = 1'b1;
    cyc();
    stack_pop = 1'b0;
    cyc(2);
    chk("stack_pointer", stack_pointer, 16'h4000);
    $display("test pointers done");
    // Register source, compare, bit and address operations
    ex_use_imm = 1'b0;
    ex_src = 4'hA;
    exe(OP_MOV, 0, 3, 0);
    ex_use_imm = 1'b1;
    rd(3, 0, 16'h0035);
    fl(FL_LOAD, 0);
    exe(OP_CMP, 0, 3, 8'h35);
    chk("flags", flg, 16'h0004);
    exe(OP_CMP, 0, 3, 8'h36);
    chk("flags", flg, 16'h0029);
    rd(3, 0, 16'h0035);
    v = $urandom & 7;
    ex_bit = v[2:0];
    exe(OP_BCLR, 0, 3, 0);
    rd(3, 0, 16'h0035 & ~(16'h0001 << v));
    exe(OP_BLOAD, 0, 3, 0);
    chk("flags", flg, 16'h0028);
    exe(OP_BSET, 0, 3, 0);
    rd(3, 0, 16'h0035 | (16'h0001 << v));
    exe(OP_ADDR_ADD, 0, 2, 16'h0102);
    rd(2, 1, 16'h1337);
    chk("flags", flg, 16'h0028);
    $display("test operations done");
    repeat (3) begin
      f = $urandom & 15;
      fl(FL_LOAD, f);
      for (int c = 0; c < 16; c++) begin
        br_cond = c[3:0];
        cyc();
        chk("br_taken", br_taken, bexp(c, f));
      end
    end
    $display("test branches done");
    wrap_up();
  end
endmodule : cpu_register_and_flag_unit_tb
